// >>> csr_pkg.sv
package csr_pkg;

  // ----------------------------------------------------------------
  // register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] CSR_CHARGE_CURRENT_OFS    = 8'h0F;
  localparam logic [7:0] CSR_MISC_CHARGE_OFS       = 8'h10;
  localparam logic [7:0] CSR_THERMAL_REDUCTION_OFS = 8'h11;
  localparam logic [7:0] CSR_THERMAL_THRESHOLD_OFS = 8'h12;

  // ----------------------------------------------------------------
  // field positions (lsb) and widths
  // ----------------------------------------------------------------
  localparam int CSR_FAST_CUR_LSB   = 0;
  localparam int CSR_FAST_CUR_W     = 4;
  localparam int CSR_WEAK_CUR_LSB   = 5;
  localparam int CSR_WEAK_CUR_W     = 2;
  localparam int CSR_RECONNECT_LSB  = 2;
  localparam int CSR_RECONNECT_W    = 3;
  localparam int CSR_INPUT_CAP_LSB  = 0;
  localparam int CSR_INPUT_CAP_W    = 2;
  localparam int CSR_VOLT_CUT_LSB   = 2;
  localparam int CSR_VOLT_CUT_W     = 2;
  localparam int CSR_CUR_LEVEL_LSB  = 0;
  localparam int CSR_CUR_LEVEL_W    = 2;
  localparam int CSR_COLD_LSB       = 5;
  localparam int CSR_COLD_W         = 3;
  localparam int CSR_HOT_LSB        = 2;
  localparam int CSR_HOT_W          = 3;
  localparam int CSR_CHILLY_BIT     = 1;
  localparam int CSR_WARM_BIT       = 0;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [3:0] CSR_FAST_CUR_RST  = 4'h6;
  localparam logic [1:0] CSR_WEAK_CUR_RST  = 2'h1;
  localparam logic [2:0] CSR_RECONNECT_RST = 3'h3;
  localparam logic [1:0] CSR_INPUT_CAP_RST = 2'h0;
  localparam logic [1:0] CSR_VOLT_CUT_RST  = 2'h2;
  localparam logic [1:0] CSR_CUR_LEVEL_RST = 2'h0;
  localparam logic [2:0] CSR_COLD_RST      = 3'h5;
  localparam logic [2:0] CSR_HOT_RST       = 3'h3;
  localparam logic       CSR_CHILLY_RST    = 1'b0;
  localparam logic       CSR_WARM_RST      = 1'b0;

  // reserved bits and unmapped reads
  localparam logic [7:0] CSR_READ_ZERO = 8'h00;

endpackage

// >>> csr_charger_regs.sv
`timescale 1ns/1ns

module csr_charger_regs
  import csr_pkg::*;
(
  input  wire logic       ref_clk_in,
  input  wire logic       rst_in,
  input  wire logic       off_state_in,
  input  wire logic       reg_reset_in,
  input  wire logic       boost_mode_entry_in,
  input  wire logic [7:0] reg_addr_in,
  input  wire logic       reg_wr_in,
  input  wire logic [7:0] reg_wdata_in,
  input  wire logic       reg_rd_in,
  output logic      [7:0] reg_rdata_out,
  output logic      [3:0] fast_charge_current_code_out,
  output logic      [1:0] low_battery_charge_current_out,
  output logic      [2:0] reconnect_threshold_code_out,
  output logic      [1:0] input_current_cap_out,
  output logic      [1:0] thermal_voltage_cut_out,
  output logic      [1:0] thermal_current_level_out,
  output logic      [2:0] cold_threshold_code_out,
  output logic      [2:0] hot_threshold_code_out,
  output logic            chilly_offset_select_out,
  output logic            warm_offset_select_out
);

  // ----------------------------------------------------------------
  // decode
  // ----------------------------------------------------------------
  wire logic       restore  = rst_in | off_state_in | reg_reset_in | boost_mode_entry_in;
  wire logic       sel_cur  = reg_addr_in == CSR_CHARGE_CURRENT_OFS;
  wire logic       sel_misc = reg_addr_in == CSR_MISC_CHARGE_OFS;
  wire logic       sel_red  = reg_addr_in == CSR_THERMAL_REDUCTION_OFS;
  wire logic       sel_thr  = reg_addr_in == CSR_THERMAL_THRESHOLD_OFS;
  wire logic       wr_cur   = reg_wr_in & sel_cur;
  wire logic       wr_misc  = reg_wr_in & sel_misc;
  wire logic       wr_red   = reg_wr_in & sel_red;
  wire logic       wr_thr   = reg_wr_in & sel_thr;

  // readback images; reserved bits are constant zero
  wire logic [7:0] img_cur  = {4'h0, fast_charge_current_code_out};
  wire logic [7:0] img_misc = {1'b0, low_battery_charge_current_out,
                               reconnect_threshold_code_out, input_current_cap_out};
  wire logic [7:0] img_red  = {4'h0, thermal_voltage_cut_out, thermal_current_level_out};
  wire logic [7:0] img_thr  = {cold_threshold_code_out, hot_threshold_code_out,
                               chilly_offset_select_out, warm_offset_select_out};
  wire logic [7:0] next_rdata = sel_cur  ? img_cur  :
                                sel_misc ? img_misc :
                                sel_red  ? img_red  :
                                sel_thr  ? img_thr  : CSR_READ_ZERO;

  // ----------------------------------------------------------------
  // field storage
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk_in) begin
    if (restore) begin
      fast_charge_current_code_out <= CSR_FAST_CUR_RST;
    end else if (wr_cur) begin
      fast_charge_current_code_out <= reg_wdata_in[CSR_FAST_CUR_LSB +: CSR_FAST_CUR_W];
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (restore) begin
      low_battery_charge_current_out <= CSR_WEAK_CUR_RST;
      reconnect_threshold_code_out   <= CSR_RECONNECT_RST;
      input_current_cap_out          <= CSR_INPUT_CAP_RST;
    end else if (wr_misc) begin
      low_battery_charge_current_out <= reg_wdata_in[CSR_WEAK_CUR_LSB +: CSR_WEAK_CUR_W];
      reconnect_threshold_code_out   <= reg_wdata_in[CSR_RECONNECT_LSB +: CSR_RECONNECT_W];
      input_current_cap_out          <= reg_wdata_in[CSR_INPUT_CAP_LSB +: CSR_INPUT_CAP_W];
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (restore) begin
      thermal_voltage_cut_out   <= CSR_VOLT_CUT_RST;
      thermal_current_level_out <= CSR_CUR_LEVEL_RST;
    end else if (wr_red) begin
      thermal_voltage_cut_out   <= reg_wdata_in[CSR_VOLT_CUT_LSB +: CSR_VOLT_CUT_W];
      thermal_current_level_out <= reg_wdata_in[CSR_CUR_LEVEL_LSB +: CSR_CUR_LEVEL_W];
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (restore) begin
      cold_threshold_code_out  <= CSR_COLD_RST;
      hot_threshold_code_out   <= CSR_HOT_RST;
      chilly_offset_select_out <= CSR_CHILLY_RST;
      warm_offset_select_out   <= CSR_WARM_RST;
    end else if (wr_thr) begin
      cold_threshold_code_out  <= reg_wdata_in[CSR_COLD_LSB +: CSR_COLD_W];
      hot_threshold_code_out   <= reg_wdata_in[CSR_HOT_LSB +: CSR_HOT_W];
      chilly_offset_select_out <= reg_wdata_in[CSR_CHILLY_BIT];
      warm_offset_select_out   <= reg_wdata_in[CSR_WARM_BIT];
    end
  end

  // ----------------------------------------------------------------
  // read port
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      reg_rdata_out <= CSR_READ_ZERO;
    end else if (reg_rd_in) begin
      reg_rdata_out <= next_rdata;
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge ref_clk_in); endclocking

  // accesses that no restore source overrides in the same cycle
  wire logic       live_wr_cur  = wr_cur & ~restore;
  wire logic       live_wr_misc = wr_misc & ~restore;
  wire logic       live_wr_red  = wr_red & ~restore;
  wire logic       live_wr_thr  = wr_thr & ~restore;
  wire logic       live_rd      = reg_rd_in & ~rst_in;
  wire logic       unmapped     = (reg_addr_in < CSR_CHARGE_CURRENT_OFS) |
                                  (reg_addr_in > CSR_THERMAL_THRESHOLD_OFS);

  AST_RESTORE_DEFAULTS: assert property (
    restore |=>
      fast_charge_current_code_out == CSR_FAST_CUR_RST &&
      low_battery_charge_current_out == CSR_WEAK_CUR_RST &&
      reconnect_threshold_code_out == CSR_RECONNECT_RST &&
      input_current_cap_out == CSR_INPUT_CAP_RST &&
      thermal_voltage_cut_out == CSR_VOLT_CUT_RST &&
      thermal_current_level_out == CSR_CUR_LEVEL_RST &&
      cold_threshold_code_out == CSR_COLD_RST &&
      hot_threshold_code_out == CSR_HOT_RST &&
      chilly_offset_select_out == CSR_CHILLY_RST &&
      warm_offset_select_out == CSR_WARM_RST)
    else $error("fields not at defaults after restore event");

  AST_FAST_WRITE: assert property (disable iff (rst_in)
    live_wr_cur |=>
      fast_charge_current_code_out == $past(reg_wdata_in[CSR_FAST_CUR_LSB +: CSR_FAST_CUR_W]))
    else $error("fast charge code not written");

  AST_FAST_READ: assert property (disable iff (rst_in)
    (live_rd && sel_cur) |=> reg_rdata_out == {4'h0, $past(fast_charge_current_code_out)})
    else $error("fast charge readback wrong");

  AST_MISC_WRITE: assert property (disable iff (rst_in)
    live_wr_misc |=>
      {low_battery_charge_current_out, reconnect_threshold_code_out,
       input_current_cap_out} == $past(reg_wdata_in[6:0]))
    else $error("misc fields not written");

  AST_MISC_READ: assert property (disable iff (rst_in)
    (live_rd && sel_misc) |=>
      reg_rdata_out == {1'b0, $past(low_battery_charge_current_out),
                        $past(reconnect_threshold_code_out), $past(input_current_cap_out)})
    else $error("misc readback wrong");

  AST_CAP_HOLDS: assert property (disable iff (rst_in)
    (!reg_wr_in && !restore) |=>
      $stable(input_current_cap_out) && $stable(fast_charge_current_code_out))
    else $error("field changed without a write");

  AST_THERMAL_RED: assert property (disable iff (rst_in)
    live_wr_red ##1 (live_rd && sel_red) |=>
      reg_rdata_out == {4'h0, $past(reg_wdata_in[3:0], 2)})
    else $error("thermal reduction write and readback differ");

  AST_LEVEL_WRITE: assert property (disable iff (rst_in)
    live_wr_red |=> thermal_current_level_out == $past(reg_wdata_in[1:0]))
    else $error("thermal current level not written");

  AST_THRESH_WRITE: assert property (disable iff (rst_in)
    live_wr_thr |=>
      {cold_threshold_code_out, hot_threshold_code_out, chilly_offset_select_out,
       warm_offset_select_out} == $past(reg_wdata_in))
    else $error("threshold fields not written");

  AST_THRESH_READ: assert property (disable iff (rst_in)
    (live_rd && sel_thr) |=>
      reg_rdata_out[7:2] == {$past(cold_threshold_code_out), $past(hot_threshold_code_out)})
    else $error("threshold readback wrong");

  AST_SELECT_READ: assert property (disable iff (rst_in)
    (live_rd && sel_thr) |=>
      reg_rdata_out[1] == $past(chilly_offset_select_out) &&
      reg_rdata_out[0] == $past(warm_offset_select_out))
    else $error("offset select readback wrong");

  AST_WARM_WRITE: assert property (disable iff (rst_in)
    live_wr_thr |=> warm_offset_select_out == $past(reg_wdata_in[CSR_WARM_BIT]))
    else $error("warm offset select not written");

  AST_RESERVED_ZERO: assert property (disable iff (rst_in)
    (live_rd && (sel_cur || sel_red)) |=> reg_rdata_out[7:4] == 4'h0)
    else $error("reserved bits read nonzero");

  AST_MISC_RESERVED: assert property (disable iff (rst_in)
    (live_rd && sel_misc) |=> !reg_rdata_out[7])
    else $error("misc reserved bit read nonzero");

  AST_UNMAPPED_ZERO: assert property (disable iff (rst_in)
    (live_rd && unmapped) |=> reg_rdata_out == CSR_READ_ZERO)
    else $error("unmapped read nonzero");

  AST_RDATA_HOLDS: assert property (disable iff (rst_in)
    (!reg_rd_in && !rst_in) |=> $stable(reg_rdata_out))
    else $error("read data changed without a read");

endmodule

// >>> csr_charger_regs_tb_top.sv
`timescale 1ns/1ns

module csr_charger_regs_tb_top;
  import csr_pkg::*;

  logic       ref_clk_in;
  logic       rst_in;
  logic [2:0] restore;
  logic [7:0] reg_addr_in;
  logic       reg_wr_in;
  logic [7:0] reg_wdata_in;
  logic       reg_rd_in;
  logic [7:0] reg_rdata_out;
  logic [3:0] fast_cur;
  logic [1:0] weak_cur;
  logic [2:0] recon;
  logic [1:0] in_cap;
  logic [1:0] volt_cut;
  logic [1:0] cur_lvl;
  logic [2:0] cold;
  logic [2:0] hot;
  logic       chilly;
  logic       warm;
  logic [7:0] fld [4];
  int         error_cnt;
  int         num_checks;

  localparam logic [7:0] ADDR [4] = '{CSR_CHARGE_CURRENT_OFS, CSR_MISC_CHARGE_OFS,
                                      CSR_THERMAL_REDUCTION_OFS, CSR_THERMAL_THRESHOLD_OFS};
  localparam logic [7:0] DEF  [4] = '{8'h06, 8'h2c, 8'h08, 8'hac};
  localparam logic [7:0] MASK [4] = '{8'h0f, 8'h7f, 8'h0f, 8'hff};
  localparam logic [7:0] PAT  [3] = '{8'hff, 8'h00, 8'ha5};

  // field outputs regrouped into register images
  assign fld[0] = {4'h0, fast_cur};
  assign fld[1] = {1'b0, weak_cur, recon, in_cap};
  assign fld[2] = {4'h0, volt_cut, cur_lvl};
  assign fld[3] = {cold, hot, chilly, warm};

  csr_charger_regs uut (
    .ref_clk_in                     (ref_clk_in),
    .rst_in                         (rst_in),
    .off_state_in                   (restore[0]),
    .reg_reset_in                   (restore[1]),
    .boost_mode_entry_in            (restore[2]),
    .reg_addr_in                    (reg_addr_in),
    .reg_wr_in                      (reg_wr_in),
    .reg_wdata_in                   (reg_wdata_in),
    .reg_rd_in                      (reg_rd_in),
    .reg_rdata_out                  (reg_rdata_out),
    .fast_charge_current_code_out   (fast_cur),
    .low_battery_charge_current_out (weak_cur),
    .reconnect_threshold_code_out   (recon),
    .input_current_cap_out          (in_cap),
    .thermal_voltage_cut_out        (volt_cut),
    .thermal_current_level_out      (cur_lvl),
    .cold_threshold_code_out        (cold),
    .hot_threshold_code_out         (hot),
    .chilly_offset_select_out       (chilly),
    .warm_offset_select_out         (warm)
  );

  // ----------------------------------------------------------------
  // clock, tasks
  // ----------------------------------------------------------------
  initial begin
    ref_clk_in = 1'b0;
    forever #10 ref_clk_in = ~ref_clk_in;
  end

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    num_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk_in);
    reg_wr_in    <= 1'b1;
    reg_addr_in  <= a;
    reg_wdata_in <= d;
    @(posedge ref_clk_in);
    reg_wr_in <= 1'b0;
    #1;
  endtask

  task automatic rd_reg(input logic [7:0] a, input logic [7:0] exp);
    @(posedge ref_clk_in);
    reg_rd_in   <= 1'b1;
    reg_addr_in <= a;
    @(posedge ref_clk_in);
    reg_rd_in <= 1'b0;
    #1;
    check(reg_rdata_out, exp);
  endtask

  task automatic all_default();
    for (int i = 0; i < 4; i++) begin
      check(fld[i], DEF[i]);
      rd_reg(ADDR[i], DEF[i]);
    end
  endtask

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge ref_clk_in);
    error_cnt++;
    wrap_up();
  end

  // ----------------------------------------------------------------
  // tests
  // ----------------------------------------------------------------
  initial begin
    rst_in = 1'b1;
    restore = 3'b000;
    reg_addr_in = 8'h00;
    reg_wr_in = 1'b0;
    reg_wdata_in = 8'h00;
    reg_rd_in = 1'b0;
    error_cnt = 0;
    num_checks = 0;
    repeat (16) @(posedge ref_clk_in);
    rst_in <= 1'b0;
    #1;
    all_default();
    $display("reset defaults test done");
    for (int p = 0; p < 3; p++) begin
      for (int i = 0; i < 4; i++) begin
        wr_reg(ADDR[i], PAT[p]);
        check(fld[i], PAT[p] & MASK[i]);
        rd_reg(ADDR[i], PAT[p] & MASK[i]);
      end
    end
    $display("write and read back test done");
    wr_reg(8'h13, 8'hff);
    wr_reg(8'h0e, 8'hff);
    rd_reg(8'h13, 8'h00);
    repeat (3) @(posedge ref_clk_in);
    check(reg_rdata_out, 8'h00);
    for (int i = 0; i < 4; i++) check(fld[i], 8'ha5 & MASK[i]);
    $display("unmapped access test done");
    // write and read of one register in the same cycle: read sees old value
    @(posedge ref_clk_in);
    reg_wr_in    <= 1'b1;
    reg_rd_in    <= 1'b1;
    reg_addr_in  <= ADDR[0];
    reg_wdata_in <= 8'h0e;
    @(posedge ref_clk_in);
    reg_wr_in <= 1'b0;
    reg_rd_in <= 1'b0;
    #1;
    check(reg_rdata_out, 8'h05);
    check(fld[0], 8'h0e);
    $display("simultaneous access test done");
    // write then read of one register on consecutive edges
    @(posedge ref_clk_in);
    reg_wr_in    <= 1'b1;
    reg_addr_in  <= ADDR[2];
    reg_wdata_in <= 8'h06;
    @(posedge ref_clk_in);
    reg_wr_in <= 1'b0;
    reg_rd_in <= 1'b1;
    @(posedge ref_clk_in);
    reg_rd_in <= 1'b0;
    #1;
    check(reg_rdata_out, 8'h06);
    check(fld[2], 8'h06);
    $display("back to back access test done");
    for (int k = 0; k < 3; k++) begin
      for (int i = 0; i < 4; i++) wr_reg(ADDR[i], 8'hff);
      rd_reg(ADDR[0], 8'h0f);
      @(posedge ref_clk_in);
      restore[k] <= 1'b1;
      wr_reg(ADDR[3], 8'h00);
      restore <= 3'b000;
      check(reg_rdata_out, 8'h0f);
      all_default();
    end
    $display("restore sources test done");
    for (int i = 0; i < 4; i++) wr_reg(ADDR[i], 8'hff);
    @(posedge ref_clk_in);
    rst_in <= 1'b1;
    @(posedge ref_clk_in);
    rst_in <= 1'b0;
    #1;
    check(reg_rdata_out, 8'h00);
    all_default();
    $display("mid-run reset test done");
    wrap_up();
  end

endmodule
